// File: core/aar_ability_regs.sv
// Local advertisement and link partner ability registers.
// Assumes a management frame engine that issues one-cycle read and write
// strobes, and an auto-negotiation engine that drives ack and received words.
`timescale 1ns/1ps
module aar_ability_regs (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic softRst,
  input wire logic [4:0] regAddr,
  input wire logic regWrEn,
  input wire logic regRdEn,
  input wire logic [15:0] regWrData,
  output logic [15:0] regRdData,
  output logic regRdValid,
  input wire logic ackSet,
  input wire logic partnerWordValid,
  input wire logic [15:0] partnerWord,
  output logic [15:0] localAdvertWord,
  output logic [15:0] partnerAbilityWord,
  input wire logic faultStatusRdClr,
  output logic faultStatusLatch
);

  typedef struct packed {
    logic [15:0] localAdv;
    logic [15:0] partner;
    logic [15:0] rdData;
    logic rdValid;
    logic faultLatch;
  } aar_state_t;

  aar_state_t state_ff;
  aar_state_t nxt_state;

  always_comb
  begin
    nxt_state = state_ff;
    nxt_state.rdValid = 1'b0;
    if (regWrEn && regAddr == aar_pkg::ADDR_LOCAL)
    begin
      nxt_state.localAdv = (state_ff.localAdv & ~aar_pkg::LOCAL_WR_MASK)
        | (regWrData & aar_pkg::LOCAL_WR_MASK);
    end
    // Acknowledge owned by hardware, write mask excludes it
    nxt_state.localAdv[aar_pkg::BIT_ACK] = ackSet;
    nxt_state.localAdv[aar_pkg::BIT_FURTHER_PAGE] = 1'b0;
    nxt_state.localAdv[aar_pkg::BIT_FOUR_PAIR] = 1'b0;
    // Partner capture, writes to address 5 are dropped
    if (partnerWordValid)
    begin
      nxt_state.partner = partnerWord & aar_pkg::PARTNER_KEEP_MASK;
    end
    // Status read clear; a new fault in the same cycle wins
    if (faultStatusRdClr)
    begin
      nxt_state.faultLatch = 1'b0;
    end
    if (partnerWordValid && partnerWord[aar_pkg::BIT_FAULT_REPORT])
    begin
      nxt_state.faultLatch = 1'b1;
    end
    // Read data registered so it cannot glitch on the frame engine
    if (regRdEn)
    begin
      nxt_state.rdValid = 1'b1;
      if (regAddr == aar_pkg::ADDR_LOCAL)
      begin
        nxt_state.rdData = state_ff.localAdv;
      end
      else if (regAddr == aar_pkg::ADDR_PARTNER)
      begin
        nxt_state.rdData = state_ff.partner;
      end
      else
      begin
        nxt_state.rdData = aar_pkg::RD_UNMAPPED;
      end
    end
    // Soft reset restores defaults; latched fault is left to status owner
    if (softRst)
    begin
      nxt_state.localAdv = aar_pkg::LOCAL_RESET;
      nxt_state.partner = aar_pkg::PARTNER_RESET;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      state_ff.localAdv <= aar_pkg::LOCAL_RESET;
      state_ff.partner <= aar_pkg::PARTNER_RESET;
      state_ff.rdData <= 16'h0000;
      state_ff.rdValid <= 1'b0;
      state_ff.faultLatch <= 1'b0;
    end
    else
    begin
      state_ff <= nxt_state;
    end
  end

  assign regRdData = state_ff.rdData;
  assign regRdValid = state_ff.rdValid;
  assign localAdvertWord = state_ff.localAdv;
  assign partnerAbilityWord = state_ff.partner;
  assign faultStatusLatch = state_ff.faultLatch;

  // Checks on the register behaviour

  local_read_a: assert property (
    @(posedge sys_clk) disable iff (rst)
    regRdEn && regAddr == aar_pkg::ADDR_LOCAL
    |=> regRdValid && regRdData == $past(localAdvertWord))
    else $error("Local word read returned wrong data");

  page_zero_a: assert property (
    @(posedge sys_clk) disable iff (rst)
    regWrEn && regAddr == aar_pkg::ADDR_LOCAL && regWrData[aar_pkg::BIT_FURTHER_PAGE]
    |=> !localAdvertWord[aar_pkg::BIT_FURTHER_PAGE])
    else $error("Further page bit took a write");

  ack_follow_a: assert property (
    @(posedge sys_clk) disable iff (rst)
    !softRst |=> localAdvertWord[aar_pkg::BIT_ACK] == $past(ackSet))
    else $error("Local acknowledge did not follow engine");

  fault_write_a: assert property (
    @(posedge sys_clk) disable iff (rst)
    regWrEn && regAddr == aar_pkg::ADDR_LOCAL && !softRst
    |=> localAdvertWord[aar_pkg::BIT_FAULT_REPORT:aar_pkg::BIT_PAUSE]
      == $past(regWrData[aar_pkg::BIT_FAULT_REPORT:aar_pkg::BIT_PAUSE]))
    else $error("Fault or pause bit write lost");

  four_pair_a: assert property (
    @(posedge sys_clk) disable iff (rst)
    regWrEn && regWrData[aar_pkg::BIT_FOUR_PAIR]
    |=> !localAdvertWord[aar_pkg::BIT_FOUR_PAIR])
    else $error("Four pair bit became set");

  speed_write_a: assert property (
    @(posedge sys_clk) disable iff (rst)
    regWrEn && regAddr == aar_pkg::ADDR_LOCAL && !softRst
    |=> localAdvertWord[aar_pkg::BIT_FAST_FULL:aar_pkg::BIT_TEN_HALF]
      == $past(regWrData[aar_pkg::BIT_FAST_FULL:aar_pkg::BIT_TEN_HALF]))
    else $error("Speed ability write lost");

  speed_reset_a: assert property (
    @(posedge sys_clk)
    rst |=> localAdvertWord[aar_pkg::BIT_FAST_FULL:aar_pkg::BIT_TEN_HALF] == 4'hf)
    else $error("Speed abilities not set by reset");

  select_write_a: assert property (
    @(posedge sys_clk) disable iff (rst)
    regWrEn && regAddr == aar_pkg::ADDR_LOCAL && !softRst
    |=> localAdvertWord[aar_pkg::SEL_MSB:aar_pkg::SEL_LSB]
      == $past(regWrData[aar_pkg::SEL_MSB:aar_pkg::SEL_LSB]))
    else $error("Selector write lost");

  select_reset_a: assert property (
    @(posedge sys_clk)
    rst || softRst
    |=> localAdvertWord[aar_pkg::SEL_MSB:aar_pkg::SEL_LSB] == aar_pkg::SEL_CSMA_CD)
    else $error("Selector not restored by reset");

  local_hold_a: assert property (
    @(posedge sys_clk) disable iff (rst)
    !(regWrEn && regAddr == aar_pkg::ADDR_LOCAL) && !softRst
    |=> $stable(localAdvertWord & aar_pkg::LOCAL_WR_MASK))
    else $error("Local word changed without a write");

  default_value_a: assert property (
    @(posedge sys_clk)
    rst || softRst |=> localAdvertWord == aar_pkg::LOCAL_RESET
      && partnerAbilityWord == aar_pkg::PARTNER_RESET)
    else $error("Defaults not restored by reset");

  read_partner_a: assert property (
    @(posedge sys_clk) disable iff (rst)
    regRdEn && regAddr == aar_pkg::ADDR_PARTNER
    |=> regRdValid && regRdData == $past(partnerAbilityWord))
    else $error("Partner word read returned wrong data");

  partner_hold_a: assert property (
    @(posedge sys_clk) disable iff (rst)
    !partnerWordValid && !softRst |=> $stable(partnerAbilityWord))
    else $error("Partner word changed without capture");

  partner_write_a: assert property (
    @(posedge sys_clk) disable iff (rst)
    regWrEn && regAddr == aar_pkg::ADDR_PARTNER && !partnerWordValid && !softRst
    |=> $stable(partnerAbilityWord))
    else $error("Partner word took a register write");

  partner_cap_a: assert property (
    @(posedge sys_clk) disable iff (rst)
    partnerWordValid && !softRst
    |=> partnerAbilityWord == ($past(partnerWord) & aar_pkg::PARTNER_KEEP_MASK))
    else $error("Partner word not captured");

  partner_ack_a: assert property (
    @(posedge sys_clk) disable iff (rst)
    partnerWordValid && !softRst
    |=> partnerAbilityWord[aar_pkg::BIT_ACK] == $past(partnerWord[aar_pkg::BIT_ACK]))
    else $error("Partner acknowledge not captured");

  partner_page_a: assert property (
    @(posedge sys_clk) disable iff (rst)
    partnerWordValid && !softRst
    |=> partnerAbilityWord[aar_pkg::BIT_FURTHER_PAGE]
      == $past(partnerWord[aar_pkg::BIT_FURTHER_PAGE]))
    else $error("Partner further page bit not captured");

  partner_fault_a: assert property (
    @(posedge sys_clk) disable iff (rst)
    partnerWordValid && !softRst
    |=> partnerAbilityWord[aar_pkg::BIT_FAULT_REPORT]
      == $past(partnerWord[aar_pkg::BIT_FAULT_REPORT]))
    else $error("Partner fault bit not captured");

  partner_select_a: assert property (
    @(posedge sys_clk) disable iff (rst)
    partnerWordValid && !softRst
    |=> partnerAbilityWord[aar_pkg::SEL_MSB:aar_pkg::SEL_LSB]
      == $past(partnerWord[aar_pkg::SEL_MSB:aar_pkg::SEL_LSB]))
    else $error("Partner selector not captured");

  partner_resv_a: assert property (
    @(posedge sys_clk) disable iff (rst)
    partnerWordValid
    |=> partnerAbilityWord[aar_pkg::BIT_RESV_HI:aar_pkg::BIT_RESV_LO] == 2'b00)
    else $error("Reserved partner bits stored");

  fault_latch_a: assert property (
    @(posedge sys_clk) disable iff (rst)
    partnerWordValid && partnerWord[aar_pkg::BIT_FAULT_REPORT]
    |=> faultStatusLatch ##1 (faultStatusLatch || $past(faultStatusRdClr)))
    else $error("Remote fault not latched");

  fault_clear_a: assert property (
    @(posedge sys_clk) disable iff (rst)
    faultStatusRdClr && !(partnerWordValid && partnerWord[aar_pkg::BIT_FAULT_REPORT])
    |=> !faultStatusLatch)
    else $error("Fault latch not cleared by status read");

  fault_quiet_a: assert property (
    @(posedge sys_clk) disable iff (rst)
    !faultStatusLatch && !(partnerWordValid && partnerWord[aar_pkg::BIT_FAULT_REPORT])
    |=> !faultStatusLatch)
    else $error("Fault latch set without a partner fault");

  read_pulse_a: assert property (
    @(posedge sys_clk) disable iff (rst)
    !regRdEn |=> !regRdValid)
    else $error("Read answer without a read");

  read_unmapped_a: assert property (
    @(posedge sys_clk) disable iff (rst)
    regRdEn && regAddr != aar_pkg::ADDR_LOCAL && regAddr != aar_pkg::ADDR_PARTNER
    |=> regRdValid && regRdData == aar_pkg::RD_UNMAPPED)
    else $error("Unmapped read returned data");

endmodule

// File: core/aar_pkg.sv
// Constants for the local and partner ability registers.
// Assumes a 5-bit management register address and 16-bit words.
package aar_pkg;
  localparam logic [4:0] ADDR_LOCAL = 5'h04;
  localparam logic [4:0] ADDR_PARTNER = 5'h05;
  localparam int BIT_FURTHER_PAGE = 15;
  localparam int BIT_ACK = 14;
  localparam int BIT_FAULT_REPORT = 13;
  localparam int BIT_RESV_HI = 12;
  localparam int BIT_RESV_LO = 11;
  localparam int BIT_PAUSE = 10;
  localparam int BIT_FOUR_PAIR = 9;
  localparam int BIT_FAST_FULL = 8;
  localparam int BIT_FAST_HALF = 7;
  localparam int BIT_TEN_FULL = 6;
  localparam int BIT_TEN_HALF = 5;
  localparam int SEL_MSB = 4;
  localparam int SEL_LSB = 0;
  localparam logic [4:0] SEL_CSMA_CD = 5'h01;
  localparam logic [15:0] LOCAL_RESET = 16'h01e1;
  // Bits 13..10 and 8..0 are held by software
  localparam logic [15:0] LOCAL_WR_MASK = 16'h3dff;
  localparam logic [15:0] PARTNER_RESET = 16'h0000;
  // Reserved partner bits 12..11 never stored
  localparam logic [15:0] PARTNER_KEEP_MASK = 16'he7ff;
  localparam logic [15:0] RD_UNMAPPED = 16'h0000;
endpackage

// File: test/aar_ability_regs_tb.sv
// Bench: register sequences and engine captures with expected words.
// Assumes the management model owns the register port.
`timescale 1ns/1ps
module aar_ability_regs_tb;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic softRst = 1'b0;
  logic ackSet = 1'b0;
  logic partnerWordValid = 1'b0;
  logic [15:0] partnerWord = 16'h0000;
  logic faultStatusRdClr = 1'b0;
  logic [4:0] regAddr;
  logic regWrEn;
  logic regRdEn;
  logic [15:0] regWrData;
  logic [15:0] regRdData;
  logic regRdValid;
  logic [15:0] localAdvertWord;
  logic [15:0] partnerAbilityWord;
  logic faultStatusLatch;
  logic [15:0] w;
  int errTotal = 0;
  int testsRun = 0;
  int cycles = 0;
  always #10 sys_clk = ~sys_clk;
  aar_ability_regs dut (.sys_clk, .rst, .softRst, .regAddr, .regWrEn, .regRdEn, .regWrData,
    .regRdData, .regRdValid, .ackSet, .partnerWordValid, .partnerWord, .localAdvertWord,
    .partnerAbilityWord, .faultStatusRdClr, .faultStatusLatch);
  aar_mgmt_model mgmt (.sys_clk, .regAddr, .regWrEn, .regRdEn, .regWrData, .regRdData,
    .regRdValid);
  task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
    testsRun++;
    if (s !== e)
    begin
      errTotal++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic report_and_stop();
    $display("errors %0d checks %0d", errTotal, testsRun);
    if (errTotal == 0 && testsRun > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic capture(input logic [15:0] v);
    @(negedge sys_clk);
    partnerWordValid = 1'b1;
    partnerWord = v;
    @(negedge sys_clk);
    partnerWordValid = 1'b0;
    partnerWord = ~v;
  endtask
  // Whole sequence needs well under 200 cycles
  always @(posedge sys_clk)
  begin
    cycles++;
    if (cycles == 1000)
    begin
      errTotal++;
      report_and_stop();
    end
  end
  initial
  begin
    repeat (2) @(negedge sys_clk);
    rst = 1'b0;
    mgmt.rd(aar_pkg::ADDR_LOCAL, w);
    chk("local reset", w, aar_pkg::LOCAL_RESET);
    @(negedge sys_clk);
    chk("read pulse", {15'h0000, regRdValid}, 16'h0000);
    mgmt.rd(aar_pkg::ADDR_PARTNER, w);
    chk("partner reset", w, 16'h0000);
    mgmt.wr(aar_pkg::ADDR_LOCAL, 16'hffff);
    mgmt.rd(aar_pkg::ADDR_LOCAL, w);
    chk("local ones", w, 16'h25ff);
    chk("advert out", localAdvertWord, 16'h25ff);
    mgmt.wr(aar_pkg::ADDR_LOCAL, 16'h0000);
    ackSet = 1'b1;
    mgmt.wr(aar_pkg::ADDR_PARTNER, 16'hffff);
    mgmt.rd(aar_pkg::ADDR_LOCAL, w);
    chk("local ack", w, 16'h4000);
    mgmt.rd(aar_pkg::ADDR_PARTNER, w);
    chk("partner ro", w, 16'h0000);
    mgmt.rd(5'h07, w);
    chk("unmapped", w, aar_pkg::RD_UNMAPPED);
    capture(16'hffff);
    mgmt.rd(aar_pkg::ADDR_PARTNER, w);
    chk("partner ones", w, 16'he7ff);
    chk("fault set", {15'h0000, faultStatusLatch}, 16'h0001);
    capture(16'h0001);
    chk("selector", partnerAbilityWord, 16'h0001);
    faultStatusRdClr = 1'b1;
    @(negedge sys_clk);
    faultStatusRdClr = 1'b0;
    chk("fault clear", {15'h0000, faultStatusLatch}, 16'h0000);
    // Faulty capture in the same cycle as the status read: the set wins
    @(negedge sys_clk);
    partnerWordValid = 1'b1;
    partnerWord = 16'h2000;
    faultStatusRdClr = 1'b1;
    @(negedge sys_clk);
    partnerWordValid = 1'b0;
    faultStatusRdClr = 1'b0;
    chk("fault set wins", {15'h0000, faultStatusLatch}, 16'h0001);
    chk("partner fault", partnerAbilityWord, 16'h2000);
    ackSet = 1'b0;
    softRst = 1'b1;
    @(negedge sys_clk);
    softRst = 1'b0;
    chk("soft local", localAdvertWord, aar_pkg::LOCAL_RESET);
    chk("soft partner", partnerAbilityWord, aar_pkg::PARTNER_RESET);
    chk("soft keeps fault", {15'h0000, faultStatusLatch}, 16'h0001);
    mgmt.wr(aar_pkg::ADDR_LOCAL, 16'h0000);
    capture(16'h00a1);
    rst = 1'b1;
    @(negedge sys_clk);
    rst = 1'b0;
    chk("reset local", localAdvertWord, aar_pkg::LOCAL_RESET);
    chk("reset partner", partnerAbilityWord, aar_pkg::PARTNER_RESET);
    chk("reset fault", {15'h0000, faultStatusLatch}, 16'h0000);
    mgmt.rd(aar_pkg::ADDR_LOCAL, w);
    chk("read after reset", w, aar_pkg::LOCAL_RESET);
    report_and_stop();
  end
endmodule

// File: test/aar_mgmt_model.sv
// Station management model driving the register strobes.
// Assumes a one-cycle registered read answer.
`timescale 1ns/1ps
module aar_mgmt_model (
  input wire logic sys_clk,
  output logic [4:0] regAddr,
  output logic regWrEn,
  output logic regRdEn,
  output logic [15:0] regWrData,
  input wire logic [15:0] regRdData,
  input wire logic regRdValid
);
  initial
  begin
    regAddr = 5'h00;
    regWrEn = 1'b0;
    regRdEn = 1'b0;
    regWrData = 16'h0000;
  end
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(negedge sys_clk);
    regAddr = a;
    regWrEn = 1'b1;
    regWrData = d & 16'ha7ff;
    @(negedge sys_clk);
    regWrEn = 1'b0;
    regAddr = ~a;
    regWrData = ~d;
  endtask
  // Data is only trusted while the answer pulse is up
  task automatic rd(input logic [4:0] a, output logic [15:0] d);
    @(negedge sys_clk);
    regAddr = a;
    regRdEn = 1'b1;
    @(negedge sys_clk);
    regRdEn = 1'b0;
    regAddr = ~a;
    d = regRdValid ? regRdData : 16'hxxxx;
  endtask
endmodule
